// ### hdl/wcc_pkg.sv
// Package for the write-data checksum checker: register map, field layout,
// code-word geometry and timing figures.
// Assumes a 32-bit APB register bus and a link clock far slower than pclk.
package wcc_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CRC    = 8'h08;
	localparam logic [7:0] ADDR_ERRCNT = 8'h0c;
	localparam logic [7:0] ADDR_WRCNT  = 8'h10;

	// Status bit positions.
	localparam int STAT_CRC_ERR   = 0;
	localparam int STAT_ORDER_ERR = 1;
	localparam int STAT_BUSY      = 2;

	// Device width codes.
	localparam logic [1:0] WIDTH_X4  = 2'h0;
	localparam logic [1:0] WIDTH_X8  = 2'h1;
	localparam logic [1:0] WIDTH_X16 = 2'h2;

	// Code-word geometry.
	localparam int CW_BITS    = 72;
	localparam int CRC_BITS   = 8;
	localparam int DATA_BEATS = 8;
	localparam int BEATS      = 10;
	localparam int BEAT_CRC   = 8;
	localparam int BEAT_LAST  = 9;
	localparam int X4_DATA    = 32;
	localparam int MASK_POS   = 64;
	localparam int HALF_BEATS = 4;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// Alert pulse width, in pclk cycles.
	localparam int ALERT_CYCLES = 4;

	// Control register layout, high bits first.
	typedef struct packed {
		logic [2:0] col_low;
		logic       auto_pre;
		logic       a2;
		logic       bc4;
		logic [1:0] width;
		logic       dbi_en;
		logic       dm_en;
		logic       crc_en;
	} wcc_ctrl_type;
	localparam int CTRL_BITS = $bits(wcc_ctrl_type);
	localparam logic [CTRL_BITS-1:0] CTRL_RESET = 11'h000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RECV  = 3'b010,
		ST_CHECK = 3'b100
	} wcc_state_type;

endpackage

// ### hdl/wcc_checker.sv
// Write-data checksum checker: receives ten-beat write bursts on the link,
// rebuilds each 72-bit code word, checks it, and commits or blocks the write.
// Assumes link pins change well away from the rising link clock edge, so
// that data synchronised alongside the clock is stable when the edge is seen.
//
// Functional notes
// - Checksum polynomial x^8+x^2+x+1, 72 bits.
// - Checksum starts from zero, no inversion.
// - Code-word bit 71 enters first.
// - Four-bit width: bits 71..32 forced one.
// - Eight-bit width: mask lane or ones above.
// - Sixteen-bit width: two identical checksum trees.
// - Mismatch drives the alert output low.
// - Without masking, writes commit despite errors.
// - Masking plus checksum: bad writes blocked.
// - Auto-precharge still happens on failed write.
// - Checksum over inverted bits, array gets restored.
// - Fixed eight-beat bursts need column 0:0:0.
// - Upper checksum covers code-word bits 143..72.
// - Column bit 2 picks chopped burst half.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module wcc_checker (
	// APB slave
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// Write link from the controller
	input  wire logic                 link_clk,
	input  wire logic                 link_start,
	input  wire logic [15:0]          link_dq,
	input  wire logic [1:0]           link_dm_n,
	output logic                      crc_error_alert_n,
	// Array side
	output logic                      core_wr_valid,
	output logic [127:0]              core_wr_data,
	output logic [15:0]               core_wr_mask_n,
	output logic                      core_precharge
);
	import wcc_pkg::*;

	// Serial shift register unrolled over the word, bit 71 first.
	function automatic logic [7:0] crc8(input logic [CW_BITS-1:0] word);
		logic [7:0] c;
		logic       fb;
		c = CRC_INIT;
		for (int i = CW_BITS - 1; i >= 0; i--) begin
			fb = c[7] ^ word[i];
			c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	// Synchronisers and link edge detection.
	logic [1:0]  clk_sync;
	logic [1:0]  start_sync;
	logic [15:0] dq_sync [0:1];
	logic [1:0]  dm_sync [0:1];
	logic        clk_prev;
	wire         link_rise = clk_sync[1] & ~clk_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sync   <= 2'h0;
			start_sync <= 2'h0;
			dq_sync[0] <= 16'h0000;
			dq_sync[1] <= 16'h0000;
			dm_sync[0] <= 2'h3;
			dm_sync[1] <= 2'h3;
			clk_prev   <= 1'b0;
		end else begin
			clk_sync   <= {clk_sync[0], link_clk};
			start_sync <= {start_sync[0], link_start};
			dq_sync[0] <= link_dq;
			dq_sync[1] <= dq_sync[0];
			dm_sync[0] <= link_dm_n;
			dm_sync[1] <= dm_sync[0];
			clk_prev   <= clk_sync[1];
		end
	end

	// Registers.
	wcc_ctrl_type ctrl;
	logic         crc_err;
	logic         order_err;
	logic [7:0]   calc_lo;
	logic [7:0]   calc_hi;
	logic [7:0]   rx_lo;
	logic [7:0]   rx_hi;
	logic [15:0]  err_cnt;
	logic [15:0]  wr_cnt;

	// Burst capture.
	wcc_state_type state;
	wcc_state_type next_state;
	logic [3:0]    beat;
	logic [15:0]   beat_dq [0:BEATS-1];
	logic [1:0]    beat_dm [0:BEATS-1];
	wire           beat_in = (state == ST_RECV) && link_rise;
	wire           burst_go = (state == ST_IDLE) && link_rise && start_sync[1];
	wire           check_fire = (state == ST_CHECK);

	always_comb begin
		case (state)
			ST_IDLE:  next_state = burst_go ? ST_RECV : ST_IDLE;
			ST_RECV:  next_state = (beat_in && beat == 4'(BEAT_LAST)) ? ST_CHECK : ST_RECV;
			ST_CHECK: next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			beat  <= 4'h0;
		end else begin
			state <= next_state;
			if (burst_go)
				beat <= 4'h1;
			else if (beat_in)
				beat <= beat + 4'h1;
		end
	end

	// Beat zero is taken with the start flag; the rest while receiving.
	always_ff @(posedge pclk) begin
		if (burst_go || beat_in) begin
			beat_dq[burst_go ? 4'h0 : beat] <= dq_sync[1];
			beat_dm[burst_go ? 4'h0 : beat] <= dm_sync[1];
		end
	end

	// Code-word assembly, one word per byte lane group.
	wire         lane_used = ctrl.dm_en | ctrl.dbi_en;
	wire         is_x4     = (ctrl.width == WIDTH_X4);
	wire         is_x16    = (ctrl.width == WIDTH_X16);
	logic [CW_BITS-1:0] word_lo;
	logic [CW_BITS-1:0] word_hi;
	logic [7:0]         rx_lo_w;
	logic [7:0]         rx_hi_w;

	always_comb begin
		word_lo = '1;
		word_hi = '1;
		for (int b = 0; b < DATA_BEATS; b++) begin
			// Chopped bursts carry ones in the second half.
			if (!(ctrl.bc4 && b >= HALF_BEATS)) begin
				for (int l = 0; l < 8; l++) begin
					word_lo[l*8+b] = beat_dq[b][l];
					word_hi[l*8+b] = beat_dq[b][8+l];
				end
				if (lane_used) begin
					word_lo[MASK_POS+b] = beat_dm[b][0];
					word_hi[MASK_POS+b] = beat_dm[b][1];
				end
			end
		end
		if (is_x4)
			word_lo[CW_BITS-1:X4_DATA] = '1;
		rx_lo_w = is_x4 ? {beat_dq[BEAT_LAST][3:0], beat_dq[BEAT_CRC][3:0]}
				: beat_dq[BEAT_CRC][7:0];
		rx_hi_w = beat_dq[BEAT_CRC][15:8];
	end

	// Received bits, still inverted, feed the trees.
	wire [7:0] crc_lo_w = crc8(word_lo);
	wire [7:0] crc_hi_w = crc8(word_hi);
	wire       bad_lo   = (crc_lo_w != rx_lo_w);
	wire       bad_hi   = is_x16 && (crc_hi_w != rx_hi_w);
	wire       mismatch = ctrl.crc_en && (bad_lo | bad_hi);
	wire       persist  = ctrl.crc_en && ctrl.dm_en;
	wire       bl8_bad  = ctrl.crc_en && !ctrl.bc4 && (ctrl.col_low != 3'h0);

	// Array data: inversion undone, chopped half placed by column bit 2.
	logic [127:0] next_data;
	logic [15:0]  next_mask_n;

	always_comb begin
		next_data   = 128'h0;
		next_mask_n = 16'h0000;
		for (int k = 0; k < 2; k++) begin
			for (int b = 0; b < DATA_BEATS; b++) begin
				int  slot;
				logic [7:0] byte_v;
				slot   = (ctrl.bc4 && ctrl.a2) ? b + HALF_BEATS : b;
				byte_v = beat_dq[b][k*8 +: 8];
				if (ctrl.dbi_en && !beat_dm[b][k])
					byte_v = ~byte_v;
				if (is_x4)
					byte_v = {4'h0, byte_v[3:0]};
				if (!(ctrl.bc4 && b >= HALF_BEATS) && (k == 0 || is_x16) && slot < DATA_BEATS) begin
					next_data[k*64 + slot*8 +: 8] = byte_v;
					next_mask_n[k*8 + slot] = !(ctrl.dm_en && !beat_dm[b][k]);
				end
			end
		end
	end

	// Commit, alert and precharge.
	logic [2:0] alert_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_wr_valid     <= 1'b0;
			core_wr_data      <= 128'h0;
			core_wr_mask_n    <= 16'h0000;
			core_precharge    <= 1'b0;
			crc_error_alert_n <= 1'b1;
			alert_cnt         <= 3'h0;
		end else begin
			// Without masking the data goes in whatever the check says.
			core_wr_valid  <= check_fire && !(persist && mismatch);
			core_precharge <= check_fire && ctrl.auto_pre;
			if (check_fire) begin
				core_wr_data   <= next_data;
				core_wr_mask_n <= next_mask_n;
			end
			if (check_fire && mismatch)
				alert_cnt <= 3'(ALERT_CYCLES);
			else if (alert_cnt != 3'h0)
				alert_cnt <= alert_cnt - 3'h1;
			crc_error_alert_n <= !((check_fire && mismatch) || alert_cnt > 3'h1);
		end
	end

	// APB slave: one wait state, so every answer comes from a flop.
	wire       access   = psel && penable && !pready;
	// Writes land at the edge that completes the transfer, when pready is seen high.
	wire       wr_acc   = psel && penable && pready && pwrite;
	wire       hit_ctrl = (paddr == ADDR_CTRL);
	wire       hit_stat = (paddr == ADDR_STATUS);
	wire       mapped   = hit_ctrl || hit_stat || (paddr == ADDR_CRC) ||
			(paddr == ADDR_ERRCNT) || (paddr == ADDR_WRCNT);
	wire [31:0] status_w = {29'h0, state != ST_IDLE, order_err, crc_err};
	logic [31:0] rd_mux;

	always_comb begin
		case (paddr)
			ADDR_CTRL:   rd_mux = {{(32-CTRL_BITS){1'b0}}, ctrl};
			ADDR_STATUS: rd_mux = status_w;
			ADDR_CRC:    rd_mux = {rx_hi, rx_lo, calc_hi, calc_lo};
			ADDR_ERRCNT: rd_mux = {16'h0000, err_cnt};
			ADDR_WRCNT:  rd_mux = {16'h0000, wr_cnt};
			default:     rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
			ctrl    <= CTRL_RESET;
		end else begin
			pready  <= access;
			pslverr <= access && !mapped;
			prdata  <= (access && !pwrite) ? rd_mux : 32'h0;
			if (wr_acc && hit_ctrl)
				ctrl <= pwdata[CTRL_BITS-1:0];
		end
	end

	// Status and counters; a new event wins over a same-cycle clear.
	wire clr_err   = wr_acc && hit_stat && pwdata[STAT_CRC_ERR];
	wire clr_order = wr_acc && hit_stat && pwdata[STAT_ORDER_ERR];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_err   <= 1'b0;
			order_err <= 1'b0;
			calc_lo   <= 8'h00;
			calc_hi   <= 8'h00;
			rx_lo     <= 8'h00;
			rx_hi     <= 8'h00;
			err_cnt   <= 16'h0000;
			wr_cnt    <= 16'h0000;
		end else begin
			crc_err   <= (check_fire && mismatch) || (crc_err && !clr_err);
			order_err <= (check_fire && bl8_bad) || (order_err && !clr_order);
			if (check_fire) begin
				calc_lo <= crc_lo_w;
				calc_hi <= crc_hi_w;
				rx_lo   <= rx_lo_w;
				rx_hi   <= rx_hi_w;
			end
			if (check_fire && mismatch)
				err_cnt <= err_cnt + 16'h0001;
			if (check_fire && !(persist && mismatch))
				wr_cnt <= wr_cnt + 16'h0001;
		end
	end

	// Checks.
	AST_ALERT_ON_MISMATCH: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire && mismatch |=> !crc_error_alert_n [*4] ##1 crc_error_alert_n)
		else $error("alert did not pulse for four cycles after a mismatch");
	AST_ALERT_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(crc_error_alert_n) |-> $past(check_fire && mismatch))
		else $error("alert fell without a mismatch");
	AST_BLOCK_BAD: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire && persist && mismatch |=> !core_wr_valid && err_cnt == $past(err_cnt) + 16'h0001)
		else $error("bad write reached the array in persistent mode");
	AST_COMMIT_PLAIN: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire && !persist |=> core_wr_valid)
		else $error("write without masking was not committed");
	AST_PRECHARGE: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire && ctrl.auto_pre |=> core_precharge)
		else $error("auto precharge lost");
	AST_X4_ONES: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire && is_x4 |-> word_lo[CW_BITS-1:X4_DATA] == 40'hff_ffff_ffff)
		else $error("upper code-word bits not forced to one");
	AST_LANE_ONES: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire && !lane_used |-> word_lo[CW_BITS-1:MASK_POS] == 8'hff)
		else $error("unused mask lane not ones");
	AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire && bl8_bad |=> order_err)
		else $error("burst order violation not flagged");
	AST_HI_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire && mismatch && bad_hi |=> crc_err && !crc_error_alert_n)
		else $error("upper byte checksum error not reported");
	AST_TEN_BEATS: assert property (@(posedge pclk) disable iff (!presetn)
		check_fire |-> beat == 4'(BEATS))
		else $error("check started without ten beats received");

	COV_GOOD: cover property (@(posedge pclk) check_fire && ctrl.crc_en && !mismatch);
	COV_BAD_BLOCK: cover property (@(posedge pclk) check_fire && persist && mismatch);
	COV_X16_HI: cover property (@(posedge pclk) check_fire && bad_hi && !bad_lo);
	COV_BC4_A2: cover property (@(posedge pclk) check_fire && ctrl.bc4 && ctrl.a2);

endmodule

// ### tb/wcc_link_model.sv
// Write-link controller model: sends ten-beat bursts on a gated link clock.
// Assumes the bench builds each burst whole, checksum beats included.
`timescale 1ns/1ps
module wcc_link_model (
	// Link pins
	output logic        link_clk,
	output logic        link_start,
	output logic [15:0] link_dq,
	output logic [1:0]  link_dm_n
);
	initial begin
		link_clk   = 1'b0;
		link_start = 1'b0;
		link_dq    = 16'h0000;
		link_dm_n  = 2'h0;
	end

	// Lanes change while the clock is low, so they are stable at each rising edge.
	task automatic send(input logic [9:0][15:0] dq, input logic [9:0][1:0] dm);
		for (int b = 0; b < 10; b++) begin
			link_start <= (b == 0);
			link_dq    <= dq[b];
			link_dm_n  <= dm[b];
			#160 link_clk <= 1'b1;
			#160 link_clk <= 1'b0;
		end
		// Released lanes show the inverse of their last value, never a stale copy.
		// No frame spacing is enforced here; a frame starts as soon as the bench calls send again.
		link_start <= 1'b0;
		link_dq    <= ~dq[9];
		link_dm_n  <= ~dm[9];
	endtask
endmodule

// ### tb/wcc_checker_tb_top.sv
// Testbench for the write-data checksum checker: APB setup, random bursts.
// Assumes the link model drives the link pins and a 25 MHz pclk.
`timescale 1ns/1ps
module wcc_checker_tb_top;
	import wcc_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic         link_clk, link_start, crc_error_alert_n, core_wr_valid, core_precharge, e;
	logic [15:0]  link_dq, core_wr_mask_n, cap_m;
	logic [1:0]   link_dm_n;
	logic [127:0] core_wr_data, cap_d;
	int           num_errors, tests_run, nerr, nwr, alerts;
	bit           got_wr, got_pre;
	integer       seed = 32'h90ae;

	wcc_checker dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .link_clk(link_clk), .link_start(link_start), .link_dq(link_dq),
		.link_dm_n(link_dm_n), .crc_error_alert_n(crc_error_alert_n),
		.core_wr_valid(core_wr_valid), .core_wr_data(core_wr_data),
		.core_wr_mask_n(core_wr_mask_n), .core_precharge(core_precharge));
	wcc_link_model lm (.link_clk(link_clk), .link_start(link_start), .link_dq(link_dq),
		.link_dm_n(link_dm_n));

	always #20 pclk = ~pclk;

	always @(posedge pclk) begin
		if (core_wr_valid === 1'b1) begin
			got_wr <= 1'b1;
			cap_d  <= core_wr_data;
			cap_m  <= core_wr_mask_n;
		end
		if (core_precharge === 1'b1) got_pre <= 1'b1;
		if (crc_error_alert_n === 1'b0) alerts <= alerts + 1;
	end

	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [127:0] ex, input logic [127:0] got);
		tests_run++;
		if (got !== ex) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			summarize();
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [7:0] crc72(input logic [71:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 71; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	task automatic burst(input int i);
		logic [9:0][15:0] dq;
		logic [9:0][1:0]  dm;
		logic [71:0]      cw;
		logic [7:0]       cr [2];
		logic [15:0]      ct;
		logic [127:0]     ed, cm;
		logic [15:0]      em, mm;
		logic [31:0]      r;
		int               w, nb, nl, s, t, hb;
		bit               ce, de, be, bc, a2, ap, bad, mis, com, oe;
		r = $random(seed);
		w = i % 3;
		nb = (w == 2) ? 2 : 1;
		nl = (w == 0) ? 4 : 8;
		ce = (i % 8 != 7);
		de = r[0];
		be = !r[0] & r[1];
		{bc, a2, ap, bad} = r[5:2];
		hb = (nb == 2 && r[9]) ? 8 : 0;
		// A nonzero column start is injected on purpose to exercise the order flag.
		oe = ce && !bc && (r[8:6] != 3'h0);
		apb(1'b1, ADDR_CTRL, {21'h0, r[8:6], ap, a2, bc, w[1:0], be, de, ce});
		for (int b = 0; b < 10; b++) begin
			dq[b] = (b > 7 || (bc && b > 3)) ? 16'hffff : 16'($random(seed));
			dm[b] = (b < 8 && (de || be) && !(bc && b > 3)) ? 2'($random(seed)) : 2'h3;
		end
		for (int k = 0; k < 2; k++) begin
			cw = '1;
			for (int b = 0; b < 8; b++) begin
				for (int l = 0; l < nl; l++) cw[l*8+b] = dq[b][k*8+l];
				cw[64+b] = (nl == 8) ? dm[b][k] : 1'b1;
			end
			cr[k] = crc72(cw);
		end
		ed = '0;
		cm = '0;
		em = '0;
		mm = '0;
		for (int k = 0; k < nb; k++) begin
			mm[k*8 +: 8] = 8'hff;
			for (int b = 0; b < (bc ? 4 : 8); b++) begin
				s = b + ((bc && a2) ? 4 : 0);
				em[k*8+s] = !de || dm[b][k];
				for (int l = 0; l < nl; l++) begin
					ed[k*64+s*8+l] = dq[b][k*8+l] ^ (be & !dm[b][k]);
					cm[k*64+s*8+l] = em[k*8+s];
				end
			end
		end
		// A reported error is answered by sending the same burst again intact.
		for (int p = 0; p < 2 && (p == 0 || mis); p++) begin
			ct = {cr[1], cr[0]};
			ct[hb] = ct[hb] ^ bad;
			if (nl == 4) begin
				dq[8][3:0] = ct[3:0];
				dq[9][3:0] = ct[7:4];
			end else dq[8] = ct;
			mis = ce & bad;
			com = !(mis & de);
			got_wr = 1'b0;
			got_pre = 1'b0;
			alerts = 0;
			lm.send(dq, dm);
			for (t = 0; t < 40 && !(got_wr || got_pre || alerts > 0); t++) @(posedge pclk);
			if (!(got_wr || got_pre || alerts > 0)) begin
				num_errors++;
				summarize();
			end
			// The alert stands four cycles; let it finish before counting.
			repeat (6) @(posedge pclk);
			chk("alert cycles", mis ? 4 : 0, alerts);
			chk("commit", com, got_wr);
			chk("precharge", ap, got_pre);
			if (com) chk("data", ed & cm, cap_d & cm);
			if (com) chk("mask", em & mm, cap_m & mm);
			apb(1'b0, ADDR_CRC, 32'h0);
			chk("crc computed", cr[0], rd[7:0]);
			chk("crc received", ct[7:0], rd[23:16]);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk("order flag", oe, rd[STAT_ORDER_ERR]);
			chk("busy", 1'b0, rd[STAT_BUSY]);
			apb(1'b1, ADDR_STATUS, 32'h2);
			nerr += mis;
			nwr += com;
			bad = 1'b0;
		end
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{num_errors, tests_run, nerr, nwr} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		chk("mapped no error", 1'b0, e);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 1'b1, e);
		chk("unmapped data", 32'h0, rd);
		for (int i = 0; i < 24; i++) burst(i);
		apb(1'b0, ADDR_ERRCNT, 32'h0);
		chk("error count", nerr, rd[15:0]);
		apb(1'b0, ADDR_WRCNT, 32'h0);
		chk("write count", nwr, rd[15:0]);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("sticky error", nerr > 0, rd[STAT_CRC_ERR]);
		apb(1'b1, ADDR_STATUS, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("sticky cleared", 1'b0, rd[STAT_CRC_ERR]);
		summarize();
	end
endmodule
